/* common/mdr_pkg.sv */
// Package of register map, field layout, reset values and timing for the device identity and reset slice
// Functional notes
// [R1] Reset at power-up and on reset-bit write
// [R2] Reset aborts activity, then operation restarts
// [R3] Reset loads every register's default value
// [R4] Slot field: strap low 001, high 111
// [R5] Slot field follows strap pin continuously
// [R6] Slot register read-only, writes ignored
// [R7] Slot register gives this device's address
// [R8] Offset 01h returns fixed maker code
// [R9] Broadcast control writes ignore bits 15-2
// [R10] Master treats slot read 000 as absent
// [R11] Reset bit reads zero after reset
package mdr_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam int ADDR_W = 6;
    localparam int DATA_W = 16;
    localparam logic [5:0] OFF_SLOT = 6'h00;
    localparam logic [5:0] OFF_MAKER = 6'h01;
    localparam logic [5:0] OFF_CTRL = 6'h05;
    localparam logic [5:0] OFF_VCAP = 6'h10;
    localparam logic [5:0] OFF_VRES = 6'h11;
    localparam logic [5:0] OFF_VCTL = 6'h12;
    localparam logic [5:0] OFF_RATE = 6'h20;

    // ------------------------------------------------------------
    // Field values and masks
    // ------------------------------------------------------------
    localparam logic [2:0] SLOT_STRAP_LOW = 3'h1;
    localparam logic [2:0] SLOT_STRAP_HIGH = 3'h7;
    localparam logic [12:0] SLOT_RSVD = 13'h0000;
    localparam int CTRL_RST_BIT = 0;
    localparam int CTRL_SHUT_BIT = 1;
    localparam int CTRL_LOW_BIT = 2;
    localparam int CTRL_FUNC1_BIT = 4;
    localparam int CTRL_FUNC2_BIT = 5;
    localparam logic [15:0] CTRL_MASK = 16'h0037;
    localparam logic [15:0] CTRL_BCAST_MASK = 16'h0003;
    localparam logic [15:0] VCTL_MASK = 16'h07ff;
    localparam logic [15:0] RATE_MASK = 16'h0003;
    localparam logic [15:0] RD_UNMAPPED = 16'h0000;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [15:0] CTRL_RST = 16'h0000;
    localparam logic [15:0] VCAP_VAL = 16'h0051;
    localparam logic [15:0] VCTL_RST = 16'h001f;
    localparam logic [15:0] RATE_RST = 16'h0002;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int RST_HOLD_CYCLES = 4;
    localparam int RST_CNT_W = 8;

    // Reset sequencer states
    typedef enum logic {
        MDR_HOLD,
        MDR_RUN
    } mdr_seq_state_t;

endpackage : mdr_pkg

/* rtl/mdr_reset_seq.sv */
// Device reset sequencer: holds the internal reset for a fixed count, then restarts
`timescale 1ns/1ps
module mdr_reset_seq #(
    parameter int RST_CYCLES = mdr_pkg::RST_HOLD_CYCLES
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic softReq,
    output logic rstActive,
    output logic restart
);

    // ------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------
    generate
        if (RST_CYCLES < 1 || RST_CYCLES > 256) begin : g_bad_cycles
            $error("RST_CYCLES must lie in 1..256");
        end
    endgenerate

    localparam logic [7:0] LAST = 8'(RST_CYCLES - 1);

    typedef struct packed {
        mdr_pkg::mdr_seq_state_t st;
        logic [7:0] cnt;
        logic restart;
    } mdr_seq_t;

    mdr_seq_t state_ff;
    mdr_seq_t nxt_state;

    // Next state: power-up starts in hold, a soft request re-enters hold
    always_comb begin
        nxt_state = state_ff;
        nxt_state.restart = 1'b0;
        case (state_ff.st)
            mdr_pkg::MDR_HOLD: begin
                if (state_ff.cnt == LAST) begin
                    nxt_state.st = mdr_pkg::MDR_RUN; // R2
                    nxt_state.cnt = 8'h00;
                    nxt_state.restart = 1'b1;
                end else begin
                    nxt_state.cnt = 8'(state_ff.cnt + 8'h01);
                end
            end
            mdr_pkg::MDR_RUN: begin
                if (softReq) begin
                    nxt_state.st = mdr_pkg::MDR_HOLD; // R1
                    nxt_state.cnt = 8'h00;
                end
            end
            default: begin
                nxt_state.st = mdr_pkg::MDR_HOLD;
                nxt_state.cnt = 8'h00;
            end
        endcase
    end

    // State register, power-up lands in hold
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_ff <= '{st: mdr_pkg::MDR_HOLD, cnt: 8'h00, restart: 1'b0}; // R1
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Outputs
    assign rstActive = (state_ff.st == mdr_pkg::MDR_HOLD);
    assign restart = state_ff.restart;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_req_enters_hold;
        @(posedge clk) disable iff (!arst_n)
        (!rstActive && softReq) |=> rstActive;
    endproperty
    a_req_enters_hold: assert property (p_req_enters_hold) else $error("soft request did not start reset"); // R1

    property p_restart_on_release;
        @(posedge clk) disable iff (!arst_n)
        $fell(rstActive) |-> restart;
    endproperty
    a_restart_on_release: assert property (p_restart_on_release) else $error("no restart pulse at release"); // R2

    property p_hold_full_count;
        @(posedge clk) disable iff (!arst_n)
        restart |-> ($past(state_ff.cnt) == LAST && $past(rstActive));
    endproperty
    a_hold_full_count: assert property (p_hold_full_count) else $error("reset hold ended early"); // R2

endmodule : mdr_reset_seq

/* rtl/mdr_identity_regs.sv */
// Register bank slice: bus slot number, maker code, device control with reset, voltage and rate registers
`timescale 1ns/1ps
module mdr_identity_regs #(
    parameter logic [15:0] MAKER_CODE = 16'h5a5a, // Arbitrary neutral value
    parameter int RST_CYCLES = mdr_pkg::RST_HOLD_CYCLES
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic strapPin,
    input wire logic [5:0] regAddr,
    input wire logic regWrEn,
    input wire logic regBcast,
    input wire logic [15:0] regWrData,
    input wire logic regRdEn,
    input wire logic [15:0] voltReadout,
    output logic [15:0] regRdData,
    output logic regRdValid,
    output logic [2:0] deviceNumber,
    output logic shutdownEn,
    output logic lowPowerEn,
    output logic [1:0] funcEnable,
    output logic [15:0] voltCtrlWord,
    output logic [1:0] rateSelect,
    output logic devRstActive,
    output logic opRestart
);

    typedef struct packed {
        logic strapMeta;
        logic strapSync;
        logic [2:0] slot;
        logic [15:0] ctrl;
        logic [15:0] vctl;
        logic [15:0] rate;
        logic [15:0] rdData;
        logic rdValid;
    } mdr_regs_t;

    mdr_regs_t state_ff;
    mdr_regs_t nxt_state;
    logic rstActive;
    logic softReq;
    logic [15:0] ctrlMask;
    logic [15:0] rdMux;

    // ------------------------------------------------------------
    // Reset sequencer
    // ------------------------------------------------------------
    mdr_reset_seq #(
        .RST_CYCLES(RST_CYCLES)
    ) u_seq (
        .clk(clk),
        .arst_n(arst_n),
        .softReq(softReq),
        .rstActive(rstActive),
        .restart(opRestart)
    );

    // Reset bit write requests a device reset
    assign softReq = regWrEn && !rstActive && (regAddr == mdr_pkg::OFF_CTRL)
                     && regWrData[mdr_pkg::CTRL_RST_BIT]; // R1

    // Broadcast writes reach only the low two control bits
    assign ctrlMask = regBcast ? mdr_pkg::CTRL_BCAST_MASK : mdr_pkg::CTRL_MASK; // R9

    // Read multiplexer, unmapped offsets read zero
    always_comb begin
        case (regAddr)
            mdr_pkg::OFF_SLOT: rdMux = {mdr_pkg::SLOT_RSVD, state_ff.slot}; // R7
            mdr_pkg::OFF_MAKER: rdMux = MAKER_CODE; // R8
            mdr_pkg::OFF_CTRL: rdMux = state_ff.ctrl;
            mdr_pkg::OFF_VCAP: rdMux = mdr_pkg::VCAP_VAL;
            mdr_pkg::OFF_VRES: rdMux = voltReadout;
            mdr_pkg::OFF_VCTL: rdMux = state_ff.vctl;
            mdr_pkg::OFF_RATE: rdMux = state_ff.rate;
            default: rdMux = mdr_pkg::RD_UNMAPPED;
        endcase
    end

    // Next state of strap synchroniser, registers and read port
    always_comb begin
        nxt_state = state_ff;
        nxt_state.strapMeta = strapPin;
        nxt_state.strapSync = state_ff.strapMeta;
        nxt_state.slot = state_ff.strapSync ? mdr_pkg::SLOT_STRAP_HIGH : mdr_pkg::SLOT_STRAP_LOW; // R4 R5 R6
        nxt_state.rdValid = 1'b0;
        if (rstActive) begin
            nxt_state.ctrl = mdr_pkg::CTRL_RST; // R3 R11
            nxt_state.vctl = mdr_pkg::VCTL_RST; // R3
            nxt_state.rate = mdr_pkg::RATE_RST; // R3
            nxt_state.rdData = 16'h0000; // R2
        end else begin
            if (regWrEn && regAddr == mdr_pkg::OFF_CTRL) begin
                nxt_state.ctrl = (state_ff.ctrl & ~ctrlMask) | (regWrData & ctrlMask); // R9
            end
            if (regWrEn && !regBcast && regAddr == mdr_pkg::OFF_VCTL) begin
                nxt_state.vctl = regWrData & mdr_pkg::VCTL_MASK;
            end
            if (regWrEn && !regBcast && regAddr == mdr_pkg::OFF_RATE) begin
                nxt_state.rate = regWrData & mdr_pkg::RATE_MASK;
            end
            if (regRdEn) begin
                nxt_state.rdData = rdMux;
                nxt_state.rdValid = 1'b1;
            end
        end
    end

    // State register
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_ff <= '{strapMeta: 1'b0, strapSync: 1'b0, slot: mdr_pkg::SLOT_STRAP_LOW,
                          ctrl: mdr_pkg::CTRL_RST, vctl: mdr_pkg::VCTL_RST, rate: mdr_pkg::RATE_RST,
                          rdData: 16'h0000, rdValid: 1'b0}; // R3
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign regRdData = state_ff.rdData;
    assign regRdValid = state_ff.rdValid;
    assign deviceNumber = state_ff.slot; // R7
    assign shutdownEn = state_ff.ctrl[mdr_pkg::CTRL_SHUT_BIT];
    assign lowPowerEn = state_ff.ctrl[mdr_pkg::CTRL_LOW_BIT];
    assign funcEnable = {state_ff.ctrl[mdr_pkg::CTRL_FUNC2_BIT], state_ff.ctrl[mdr_pkg::CTRL_FUNC1_BIT]};
    assign voltCtrlWord = state_ff.vctl;
    assign rateSelect = state_ff.rate[1:0];
    assign devRstActive = rstActive;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_slot_map;
        @(posedge clk) disable iff (!arst_n)
        ##1 (deviceNumber == ($past(state_ff.strapSync) ? 3'h7 : 3'h1));
    endproperty
    a_slot_map: assert property (p_slot_map) else $error("slot field does not match strap"); // R4

    property p_slot_follow;
        @(posedge clk) disable iff (!arst_n)
        $rose(state_ff.strapSync) |=> (deviceNumber == 3'h7) ##1 (deviceNumber == 3'h7 || !$past(state_ff.strapSync));
    endproperty
    a_slot_follow: assert property (p_slot_follow) else $error("slot field did not follow strap"); // R5

    property p_slot_ro;
        @(posedge clk) disable iff (!arst_n)
        (regWrEn && regAddr == 6'h00 && $stable(state_ff.strapSync)) |=> $stable(deviceNumber);
    endproperty
    a_slot_ro: assert property (p_slot_ro) else $error("write changed slot field"); // R6

    property p_slot_read;
        @(posedge clk) disable iff (!arst_n)
        (regRdEn && !rstActive && regAddr == 6'h00) |=> (regRdValid && regRdData == {13'h0000, $past(deviceNumber)});
    endproperty
    a_slot_read: assert property (p_slot_read) else $error("slot read returned wrong value"); // R7

    property p_maker_read;
        @(posedge clk) disable iff (!arst_n)
        (regRdEn && !rstActive && regAddr == 6'h01) |=> (regRdValid && regRdData == MAKER_CODE);
    endproperty
    a_maker_read: assert property (p_maker_read) else $error("maker code read wrong"); // R8

    property p_soft_reset;
        @(posedge clk) disable iff (!arst_n)
        (regWrEn && !rstActive && regAddr == 6'h05 && regWrData[0]) |=> devRstActive;
    endproperty
    a_soft_reset: assert property (p_soft_reset) else $error("reset bit write did not reset"); // R1

    property p_defaults;
        @(posedge clk) disable iff (!arst_n)
        rstActive |=> (state_ff.ctrl == 16'h0000 && voltCtrlWord == 16'h001f && state_ff.rate == 16'h0002);
    endproperty
    a_defaults: assert property (p_defaults) else $error("registers not at defaults during reset"); // R3

    property p_abort;
        @(posedge clk) disable iff (!arst_n)
        rstActive |=> !regRdValid;
    endproperty
    a_abort: assert property (p_abort) else $error("read completed during reset"); // R2

    property p_bcast;
        @(posedge clk) disable iff (!arst_n)
        (regWrEn && regBcast && !rstActive && regAddr == 6'h05)
            |=> ((state_ff.ctrl & 16'hfffc) == ($past(state_ff.ctrl) & 16'hfffc));
    endproperty
    a_bcast: assert property (p_bcast) else $error("broadcast write changed bits 15-2"); // R9

    property p_self_clear;
        @(posedge clk) disable iff (!arst_n)
        $fell(devRstActive) |-> !state_ff.ctrl[0];
    endproperty
    a_self_clear: assert property (p_self_clear) else $error("reset bit still set after reset"); // R11

    property p_bcast_low;
        @(posedge clk) disable iff (!arst_n)
        (regWrEn && regBcast && !rstActive && regAddr == 6'h05)
            |=> (state_ff.ctrl[1:0] == $past(regWrData[1:0]));
    endproperty
    a_bcast_low: assert property (p_bcast_low) else $error("broadcast write to control not taken"); // R9

    property p_bcast_other;
        @(posedge clk) disable iff (!arst_n)
        (regWrEn && regBcast && !rstActive && regAddr != 6'h05)
            |=> ($stable(voltCtrlWord) && $stable(rateSelect));
    endproperty
    a_bcast_other: assert property (p_bcast_other) else $error("broadcast write changed another register"); // R9

    property p_rd_cleared;
        @(posedge clk) disable iff (!arst_n)
        rstActive |=> (regRdData == 16'h0000);
    endproperty
    a_rd_cleared: assert property (p_rd_cleared) else $error("read data kept during reset"); // R2

    property p_restart_once;
        @(posedge clk) disable iff (!arst_n)
        opRestart |=> !opRestart;
    endproperty
    a_restart_once: assert property (p_restart_once) else $error("restart pulse longer than one cycle"); // R2

    property p_slot_values;
        @(posedge clk) disable iff (!arst_n)
        (deviceNumber == 3'h1 || deviceNumber == 3'h7);
    endproperty
    a_slot_values: assert property (p_slot_values) else $error("slot field holds an unassigned number"); // R4

endmodule : mdr_identity_regs

/* test/mdr_host_model.sv */
// Register port master model standing in for the serial bus front end
`timescale 1ns/1ps
module mdr_host_model (
    input wire logic clk,
    input wire logic [15:0] regRdData,
    input wire logic regRdValid,
    output logic [5:0] regAddr,
    output logic regWrEn,
    output logic regBcast,
    output logic [15:0] regWrData,
    output logic regRdEn
);
    // Idle lines before the first request
    initial begin
        regAddr = 6'h2a;
        regWrEn = 1'b0;
        regBcast = 1'b0;
        regWrData = 16'h5555;
        regRdEn = 1'b0;
    end

    // One idle edge first, then strobe held one falling edge to the next, released lines scrambled
    task automatic access(input logic [5:0] a, input logic [15:0] d, input logic wr, input logic bc,
                          output logic [15:0] q, output logic v);
        @(negedge clk);
        regAddr = a;
        regWrData = d;
        regWrEn = wr;
        regRdEn = !wr;
        regBcast = bc;
        @(posedge clk);
        @(negedge clk);
        q = regRdData;
        v = regRdValid;
        regWrEn = 1'b0;
        regRdEn = 1'b0;
        regAddr = ~a;
        regWrData = ~d;
        regBcast = ~bc;
    endtask : access

    // Probe: a slot value of 000 means nobody answers at this number
    task automatic probe(output logic present);
        logic [15:0] q;
        logic v;
        access(6'h00, 16'h0000, 1'b0, 1'b0, q, v);
        present = v && (q[2:0] != 3'h0);
    endtask : probe
endmodule : mdr_host_model

/* test/tb.sv */
// Self-checking bench for the identity and reset register slice
`timescale 1ns/1ps
module tb;
    localparam int RST = 5; // Long enough to refuse two spaced requests in one hold
    localparam logic [15:0] MAKER = 16'h3c3c; // Arbitrary neutral value
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic strapPin = 1'b0;
    logic [15:0] voltReadout = 16'h0000;
    logic [5:0] regAddr;
    logic regWrEn;
    logic regBcast;
    logic [15:0] regWrData;
    logic regRdEn;
    logic [15:0] regRdData;
    logic regRdValid;
    logic [2:0] deviceNumber;
    logic shutdownEn;
    logic lowPowerEn;
    logic [1:0] funcEnable;
    logic [15:0] voltCtrlWord;
    logic [1:0] rateSelect;
    logic devRstActive;
    logic opRestart;
    int miscompares = 0;
    int totalChecks = 0;
    int seed = 32'h8abb5374;
    int n;
    logic [15:0] ctrl, vctl, rate, q, d;
    logic v, p;
    logic [5:0] addrs [8] = '{6'h00, 6'h01, 6'h05, 6'h10, 6'h11, 6'h12, 6'h20, 6'h3f};
    logic [5:0] ro [4] = '{6'h00, 6'h01, 6'h10, 6'h11};
    logic [5:0] rw [4] = '{6'h05, 6'h12, 6'h20, 6'h0c};

    // Clock
    always #5 clk = ~clk;

    mdr_identity_regs #(.MAKER_CODE(MAKER), .RST_CYCLES(RST)) dut (.clk(clk), .arst_n(arst_n),
        .strapPin(strapPin), .regAddr(regAddr), .regWrEn(regWrEn), .regBcast(regBcast),
        .regWrData(regWrData), .regRdEn(regRdEn), .voltReadout(voltReadout), .regRdData(regRdData),
        .regRdValid(regRdValid), .deviceNumber(deviceNumber), .shutdownEn(shutdownEn),
        .lowPowerEn(lowPowerEn), .funcEnable(funcEnable), .voltCtrlWord(voltCtrlWord),
        .rateSelect(rateSelect), .devRstActive(devRstActive), .opRestart(opRestart));

    mdr_host_model mst (.clk(clk), .regRdData(regRdData), .regRdValid(regRdValid), .regAddr(regAddr),
        .regWrEn(regWrEn), .regBcast(regBcast), .regWrData(regWrData), .regRdEn(regRdEn));

    // ------------------------------------------------------------
    // Compare, model and bus tasks
    // ------------------------------------------------------------
    task automatic chkw(input string what, input logic [15:0] e, input logic [15:0] g);
        totalChecks++;
        if (g !== e) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, e, g);
        end
    endtask : chkw

    task automatic chkb(input string what, input logic e, input logic g);
        totalChecks++;
        if (g !== e) begin
            miscompares++;
            $display("BAD %s expected %b seen %b", what, e, g);
        end
    endtask : chkb

    function automatic logic [15:0] expect_rd(input logic [5:0] a);
        case (a)
            6'h00: return {13'h0000, strapPin ? 3'h7 : 3'h1};
            6'h01: return MAKER;
            6'h05: return ctrl;
            6'h10: return 16'h0051;
            6'h11: return voltReadout;
            6'h12: return vctl;
            6'h20: return rate;
            default: return 16'h0000;
        endcase
    endfunction : expect_rd

    task automatic dflt();
        ctrl = 16'h0000;
        vctl = 16'h001f;
        rate = 16'h0002;
    endtask : dflt

    task automatic wr(input logic [5:0] a, input logic [15:0] dd, input logic bc);
        mst.access(a, dd, 1'b1, bc, q, v);
        if (a == 6'h05) ctrl = bc ? {ctrl[15:2], dd[1:0]} : (dd & 16'h0037);
        else if (!bc && a == 6'h12) vctl = dd & 16'h07ff;
        else if (!bc && a == 6'h20) rate = dd & 16'h0003;
        if (a == 6'h05 && dd[0]) dflt();
    endtask : wr

    task automatic rd(input logic [5:0] a);
        mst.access(a, 16'h0000, 1'b0, 1'b0, q, v);
        chkb("read valid", 1'b1, v);
        chkw("read data", expect_rd(a), q);
    endtask : rd

    task automatic chk_outs();
        chkw("control outs", {12'h000, ctrl[5:4], ctrl[2:1]},
             {12'h000, funcEnable, lowPowerEn, shutdownEn});
        chkw("voltage control", vctl, voltCtrlWord);
        chkw("rate", rate, {14'h0000, rateSelect});
        chkw("slot", {13'h0000, strapPin ? 3'h7 : 3'h1}, {13'h0000, deviceNumber});
    endtask : chk_outs

    task automatic wait_rst(input int e);
        n = 0;
        while (devRstActive === 1'b1 && n < 300) begin
            n++;
            @(negedge clk);
        end
        chkw("hold cycles", 16'(e), n[15:0]);
        chkb("restart pulse", 1'b1, opRestart);
    endtask : wait_rst

    task automatic close_out();
        $display("checks %0d mismatches %0d", totalChecks, miscompares);
        if (miscompares == 0 && totalChecks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : close_out

    // Watchdog
    initial begin
        #200000;
        miscompares++;
        close_out();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        dflt();
        voltReadout = 16'($random(seed));
        repeat (6) @(negedge clk);
        arst_n = 1'b1;
        wait_rst(RST);
        foreach (addrs[i]) rd(addrs[i]);
        chk_outs();
        for (int s = 0; s < 2; s++) begin
            strapPin = ~strapPin;
            repeat (4) @(negedge clk);
            chk_outs();
            rd(6'h00);
            mst.probe(p);
            chkb("device present", 1'b1, p);
        end
        for (int i = 0; i < 4; i++) begin
            wr(ro[i], 16'($random(seed)), 1'b0);
            rd(ro[i]);
        end
        repeat (16) begin
            d = 16'($random(seed)) & 16'hfffe;
            voltReadout = 16'($random(seed));
            wr(rw[$unsigned($random(seed)) % 4], d, d[15] ^ d[3]);
            chk_outs();
            rd(6'h05);
            rd(6'h11);
        end
        wr(6'h12, 16'h0555, 1'b0);
        wr(6'h05, 16'h0037, 1'b0);
        wait_rst(RST);
        rd(6'h05);
        chk_outs();
        wr(6'h20, 16'h0001, 1'b0);
        wr(6'h05, 16'h0003, 1'b1);
        mst.access(6'h05, 16'h0000, 1'b0, 1'b0, q, v);
        chkb("refused read", 1'b0, v);
        mst.access(6'h12, 16'h0222, 1'b1, 1'b0, q, v);
        // Four hold edges already spent on the refused pair
        wait_rst(RST - 4);
        foreach (addrs[i]) rd(addrs[i]);
        wr(6'h12, 16'h0333, 1'b0);
        arst_n = 1'b0;
        dflt();
        @(negedge clk);
        chk_outs();
        arst_n = 1'b1;
        wait_rst(RST);
        rd(6'h12);
        close_out();
    end
endmodule : tb
